// [hdl/ads_engine.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Angles are 16-bit, wrapping every 65536 counts
// - Sensor reading mapped onto the full-turn range
// - Offset add rotates forward, subtract rotates back
// - Third current is negated sum of two
// - Single-ended mode grounds negative input internally
// - Zero-pulse channel readback only, never zeroes
// - Supply voltage delivered raw unsigned, unscaled
// - Brake switches on raw supply vs thresholds
// - Injected samples may replace raw currents
// - General inputs raw; first may be target
// - Raw samples readable; currents show injected values when selected
// - Unsigned offset subtracted giving signed result
// - Signed gain; negative inverts current direction
// - Scaled current and encoder values readable
// - All channels processed in parallel together
// - Most negative value clipped to one above
module ads_engine
  import ads_pkg::*;
#(
  parameter int POS_W      = ADS_POS_W_DEF,
  parameter int GAIN_SHIFT = ADS_GAIN_SHIFT_DEF
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      in_valid,
  input  wire ads_sample_s               in_sample,
  input  wire ads_cfg_s                  cfg,
  input  wire logic                      out_ready,
  output logic                           in_ready,
  output logic                           out_valid,
  output ads_result_s                    out_result,
  output logic                           brake_out,
  output logic [ADS_NUM_SCALED-1:0]      neg_input_gnd
);

  // Clip to the symmetric signed 16-bit range
  function automatic logic [ADS_SAMPLE_W-1:0] sat16(input logic signed [ADS_WIDE_W-1:0] x);
    logic signed [ADS_WIDE_W-1:0] y;
    y = x;
    if (x > ADS_SAT_HI) begin
      y = ADS_SAT_HI;
    end else if (x < ADS_SAT_LO) begin
      y = ADS_SAT_LO;
    end
    return y[ADS_SAMPLE_W-1:0];
  endfunction

  logic              push;
  logic              pop;
  ads_raw_t          sel_raw;
  ads_chan_t         scaled;
  ads_result_s       new_res;
  logic signed [ADS_WIDE_W-1:0] cur_sum;
  logic [ADS_ANGLE_W-1:0] mapped_angle;
  logic [ADS_ANGLE_W-1:0] mech_angle;
  logic [ADS_ANGLE_W+ADS_POLE_W-1:0] elec_prod;

  ads_result_s head_q, head_d;
  ads_result_s spare_q, spare_d;
  logic        head_v_q, head_v_d;
  logic        spare_v_q, spare_v_d;
  logic        in_ready_q, in_ready_d;
  logic        brake_q, brake_d;
  logic [ADS_NUM_SCALED-1:0] neg_gnd_q, neg_gnd_d;

  assign push = in_valid && in_ready_q;
  assign pop  = head_v_q && out_ready;

  // Injected values replace the two measured currents when selected
  always_comb begin
    sel_raw = in_sample.raw;
    if (cfg.inject_sel) begin
      sel_raw[ADS_CURRENT_SENSE_CH0] = cfg.inject_ch0;
      sel_raw[ADS_CURRENT_SENSE_CH1] = cfg.inject_ch1;
    end
  end

  // One scaler for each of the five current and encoder channels, all working on the same sample set
  for (genvar c = 0; c < ADS_NUM_SCALED; c++) begin : g_scale
    logic signed [ADS_DIFF_W-1:0]   diff;
    logic signed [ADS_WIDE_W-1:0]   prod;
    // Offset is unsigned, so widen both with a zero before subtracting
    assign diff = $signed({1'b0, sel_raw[c]}) - $signed({1'b0, cfg.offset[c]});
    // Gain is signed; a negative gain flips the sign of the result
    // Widen both factors first so the product keeps every bit
    assign prod = ADS_WIDE_W'(diff) * ADS_WIDE_W'($signed(cfg.gain[c]));
    assign scaled[c] = sat16(prod >>> GAIN_SHIFT);
  end

  // Third current from the two measured ones
  assign cur_sum = -(ADS_WIDE_W'($signed(scaled[ADS_CURRENT_SENSE_CH0]))
                   + ADS_WIDE_W'($signed(scaled[ADS_CURRENT_SENSE_CH1])));

  // Sensor reading left aligned into the full turn, then offset rotation
  always_comb begin
    mapped_angle = ADS_ANGLE_W'(in_sample.pos_reading[POS_W-1:0]) << (ADS_ANGLE_W-POS_W);
    // Modulo 2**16 wrap is the natural overflow of the 16-bit adder
    if (cfg.offset_sub) begin
      mech_angle = mapped_angle - cfg.angle_offset;
    end else begin
      mech_angle = mapped_angle + cfg.angle_offset;
    end
    elec_prod = mech_angle * cfg.pole_pairs;
  end

  // Assemble the result; zero pulse is only reported, never used on angles
  always_comb begin
    new_res                     = '0;
    new_res.raw                 = sel_raw;
    new_res.scaled              = scaled;
    new_res.derived_current_ch2 = sat16(cur_sum);
    new_res.sensor_angle        = mapped_angle;
    new_res.mechanical_angle    = mech_angle;
    new_res.electrical_angle    = elec_prod[ADS_ANGLE_W-1:0];
    new_res.supply_voltage_ch   = sel_raw[ADS_SUPPLY_VOLTAGE_CH];
    new_res.analog_target       = cfg.target_from_gpa ? sel_raw[ADS_GP_ANALOG_IN_A] : ADS_ZERO16;
    new_res.analog_target_valid = cfg.target_from_gpa;
  end

  // Two-entry buffer: head drives the outputs, spare absorbs one stall
  always_comb begin
    head_d    = head_q;
    head_v_d  = head_v_q;
    spare_d   = spare_q;
    spare_v_d = spare_v_q;
    if (pop || !head_v_q) begin
      if (spare_v_q) begin
        head_d    = spare_q;
        head_v_d  = 1'b1;
        spare_v_d = push;
        if (push) begin
          spare_d = new_res;
        end
      end else begin
        head_v_d = push;
        if (push) begin
          head_d = new_res;
        end
      end
    end else if (push) begin
      spare_d   = new_res;
      spare_v_d = 1'b1;
    end
    // Ready registered, so refuse while the spare is taken
    in_ready_d = !spare_v_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_q     <= '0;
      spare_q    <= '0;
      head_v_q   <= 1'b0;
      spare_v_q  <= 1'b0;
      in_ready_q <= 1'b0;
    end else begin
      head_q     <= head_d;
      spare_q    <= spare_d;
      head_v_q   <= head_v_d;
      spare_v_q  <= spare_v_d;
      in_ready_q <= in_ready_d;
    end
  end

  // Brake hysteresis on the raw supply sample; on threshold wins
  always_comb begin
    brake_d = brake_q;
    if (push) begin
      if (new_res.supply_voltage_ch >= cfg.brake_on_thr) begin
        brake_d = 1'b1;
      end else if (new_res.supply_voltage_ch <= cfg.brake_off_thr) begin
        brake_d = 1'b0;
      end
    end
    // Analog front end grounds the negative leg in single-ended mode
    neg_gnd_d = cfg.single_ended;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_q   <= ADS_BRAKE_RST;
      neg_gnd_q <= '0;
    end else begin
      brake_q   <= brake_d;
      neg_gnd_q <= neg_gnd_d;
    end
  end

  assign in_ready      = in_ready_q;
  assign out_valid     = head_v_q;
  assign out_result    = head_q;
  assign brake_out     = brake_q;
  assign neg_input_gnd = neg_gnd_q;

  // Angle checks against the full-turn count, not the adder itself
  a_mech_add: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && !cfg.offset_sub |-> new_res.mechanical_angle
      == ADS_ANGLE_W'((int'(new_res.sensor_angle) + int'(cfg.angle_offset)) % ADS_ANGLE_TURN))
    else $error("forward rotation wrong");

  // Subtraction wraps backwards through zero
  a_mech_sub: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && cfg.offset_sub |-> new_res.mechanical_angle
      == ADS_ANGLE_W'((int'(new_res.sensor_angle) - int'(cfg.angle_offset) + ADS_ANGLE_TURN) % ADS_ANGLE_TURN))
    else $error("backward rotation wrong");

  // Reading scaled so its full range spans one turn
  a_sensor_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> new_res.sensor_angle
      == ADS_ANGLE_W'(int'(in_sample.pos_reading[POS_W-1:0]) * (ADS_ANGLE_TURN >> POS_W)))
    else $error("sensor reading not mapped to a turn");

  // Electrical angle wraps modulo one turn
  a_elec_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> new_res.electrical_angle
      == ADS_ANGLE_W'((int'(new_res.mechanical_angle) * int'(cfg.pole_pairs)) % ADS_ANGLE_TURN))
    else $error("electrical angle wrap wrong");

  // Target source follows the select, zero otherwise
  a_target_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> new_res.analog_target
      == (cfg.target_from_gpa ? in_sample.raw[ADS_GP_ANALOG_IN_A] : ADS_ZERO16))
    else $error("analog target source wrong");

  // General inputs pass through untouched
  a_gp_raw: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> (new_res.raw[ADS_GP_ANALOG_IN_A] == in_sample.raw[ADS_GP_ANALOG_IN_A])
      && (new_res.raw[ADS_GP_ANALOG_IN_B] == in_sample.raw[ADS_GP_ANALOG_IN_B]))
    else $error("general input altered");

  // Zero pulse is only handed on for readback
  a_zero_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> new_res.raw[ADS_ANALOG_POS_CH_V] == in_sample.raw[ADS_ANALOG_POS_CH_V])
    else $error("zero pulse channel altered");

  // Encoder raw values readable as sampled
  a_enc_raw: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> (new_res.raw[ADS_ANALOG_POS_CH_U] == in_sample.raw[ADS_ANALOG_POS_CH_U])
      && (new_res.raw[ADS_ANALOG_POS_CH_W] == in_sample.raw[ADS_ANALOG_POS_CH_W]))
    else $error("encoder raw value altered");

  // A zero gain must give a zero result whatever the offset
  a_zero_gain: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && (cfg.gain[ADS_CURRENT_SENSE_CH1] == ADS_ZERO16)
    |-> new_res.scaled[ADS_CURRENT_SENSE_CH1] == ADS_ZERO16)
    else $error("zero gain gave a result");

  // Sample equal to its offset always scales to zero
  a_offset_null: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && (sel_raw[ADS_CURRENT_SENSE_CH0] == cfg.offset[ADS_CURRENT_SENSE_CH0])
    |-> new_res.scaled[ADS_CURRENT_SENSE_CH0] == ADS_ZERO16)
    else $error("offset not removed");

  // Empty buffer shows a taken set one edge later
  a_empty_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && !head_v_q |=> out_valid)
    else $error("result not presented");

  // Taking a result always frees room for the next set
  a_pop_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_valid && out_ready |=> in_ready)
    else $error("ready not restored after pop");

  // Single-ended select never leaks onto differential channels
  a_gnd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg.single_ended == '0) |=> (neg_input_gnd == '0))
    else $error("negative leg grounded in differential mode");

  // Checks on the delivered results, the taken sets and the brake and ground outputs
  a_i2_kirchhoff: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_valid && (out_result.scaled[ADS_CURRENT_SENSE_CH0] != ADS_S16_MIN)
    && ($signed(out_result.scaled[ADS_CURRENT_SENSE_CH0]) + $signed(out_result.scaled[ADS_CURRENT_SENSE_CH1])
        <= 32767)
    && ($signed(out_result.scaled[ADS_CURRENT_SENSE_CH0]) + $signed(out_result.scaled[ADS_CURRENT_SENSE_CH1])
        >= -32767)
    |-> ($signed(out_result.scaled[ADS_CURRENT_SENSE_CH0]) + $signed(out_result.scaled[ADS_CURRENT_SENSE_CH1])
         + $signed(out_result.derived_current_ch2)) == 0)
    else $error("third current is not the negated sum");

  a_no_min_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_valid |-> (out_result.derived_current_ch2 != ADS_S16_MIN)
      && (out_result.scaled[0] != ADS_S16_MIN)
      && (out_result.scaled[1] != ADS_S16_MIN)
      && (out_result.scaled[2] != ADS_S16_MIN)
      && (out_result.scaled[3] != ADS_S16_MIN)
      && (out_result.scaled[4] != ADS_S16_MIN))
    else $error("most negative code reached an output");

  a_angle_rotate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> ADS_ANGLE_W'(new_res.mechanical_angle - new_res.sensor_angle)
      == (cfg.offset_sub ? ADS_ANGLE_W'(-cfg.angle_offset) : cfg.angle_offset))
    else $error("angle offset rotation wrong");

  a_brake_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && (in_sample.raw[ADS_SUPPLY_VOLTAGE_CH] >= cfg.brake_on_thr) |=> brake_out)
    else $error("brake not switched on");

  a_brake_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && (in_sample.raw[ADS_SUPPLY_VOLTAGE_CH] < cfg.brake_on_thr)
    && (in_sample.raw[ADS_SUPPLY_VOLTAGE_CH] <= cfg.brake_off_thr) |=> !brake_out)
    else $error("brake not switched off");

  a_brake_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !push |=> $stable(brake_out))
    else $error("brake changed without a sample");

  a_neg_gnd_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 neg_input_gnd == $past(cfg.single_ended))
    else $error("single-ended ground select lags");

  a_inject_used: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && !head_v_q && !spare_v_q && cfg.inject_sel
    |=> out_valid && (out_result.raw[ADS_CURRENT_SENSE_CH0] == $past(cfg.inject_ch0))
      && (out_result.raw[ADS_CURRENT_SENSE_CH1] == $past(cfg.inject_ch1)))
    else $error("injected sample not selected");

  a_vm_raw: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push && !head_v_q && !spare_v_q && !cfg.inject_sel
    |=> out_result.supply_voltage_ch == $past(in_sample.raw[ADS_SUPPLY_VOLTAGE_CH]))
    else $error("supply voltage altered");

  a_stall_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_result))
    else $error("result lost during stall");

  a_full_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    out_valid && !out_ready && !in_ready |=> !in_ready)
    else $error("buffer accepted while full");

  c_full_stall: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push ##1 push ##1 !in_ready [*2]);
  c_brake_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !brake_out ##1 brake_out ##[1:50] !brake_out);
  c_inject: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push && cfg.inject_sel);
  c_clip: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push && (new_res.derived_current_ch2 == 16'h8001));
  c_angle_sub: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push && cfg.offset_sub);

endmodule

`default_nettype wire

// [hdl/ads_pkg.sv]
package ads_pkg;

  // Sample and angle widths
  localparam int ADS_SAMPLE_W       = 16;
  localparam int ADS_ANGLE_W        = 16;
  localparam int ADS_NUM_RAW        = 8;
  localparam int ADS_NUM_SCALED     = 5;
  localparam int ADS_POLE_W         = 8;
  localparam int ADS_DIFF_W         = ADS_SAMPLE_W + 1;
  localparam int ADS_WIDE_W         = 34;
  localparam int ADS_POS_W_DEF      = 16;
  localparam int ADS_GAIN_SHIFT_DEF = 8;

  // One full turn spans 2**16 counts
  localparam int ADS_ANGLE_TURN = 65536;

  // Index of each channel in the raw sample vector
  localparam int ADS_CURRENT_SENSE_CH0 = 0;
  localparam int ADS_CURRENT_SENSE_CH1 = 1;
  localparam int ADS_ANALOG_POS_CH_U   = 2;
  localparam int ADS_ANALOG_POS_CH_V   = 3;
  localparam int ADS_ANALOG_POS_CH_W   = 4;
  localparam int ADS_SUPPLY_VOLTAGE_CH = 5;
  localparam int ADS_GP_ANALOG_IN_A    = 6;
  localparam int ADS_GP_ANALOG_IN_B    = 7;

  // Signed clip limits; the most negative code is never produced
  localparam logic signed [ADS_WIDE_W-1:0] ADS_SAT_HI = 34'sh0_0000_7FFF;
  localparam logic signed [ADS_WIDE_W-1:0] ADS_SAT_LO = -34'sh0_0000_7FFF;
  localparam logic [ADS_SAMPLE_W-1:0]      ADS_S16_MIN = 16'h8000;
  localparam logic [ADS_SAMPLE_W-1:0]      ADS_ZERO16  = 16'h0000;
  localparam logic                         ADS_BRAKE_RST = 1'b0;

  typedef logic [ADS_NUM_RAW-1:0][ADS_SAMPLE_W-1:0]    ads_raw_t;
  typedef logic [ADS_NUM_SCALED-1:0][ADS_SAMPLE_W-1:0] ads_chan_t;

  // One decimated sample set from all channels plus the sensor reading
  typedef struct packed {
    ads_raw_t                  raw;
    logic [ADS_SAMPLE_W-1:0]   pos_reading;
  } ads_sample_s;

  // Static configuration driven by the surrounding control logic
  typedef struct packed {
    ads_chan_t                 offset;
    ads_chan_t                 gain;
    logic [ADS_SAMPLE_W-1:0]   inject_ch0;
    logic [ADS_SAMPLE_W-1:0]   inject_ch1;
    logic                      inject_sel;
    logic [ADS_NUM_SCALED-1:0] single_ended;
    logic [ADS_ANGLE_W-1:0]    angle_offset;
    logic                      offset_sub;
    logic [ADS_POLE_W-1:0]     pole_pairs;
    logic [ADS_SAMPLE_W-1:0]   brake_on_thr;
    logic [ADS_SAMPLE_W-1:0]   brake_off_thr;
    logic                      target_from_gpa;
  } ads_cfg_s;

  // Processed result of one sample set
  typedef struct packed {
    ads_raw_t                  raw;
    ads_chan_t                 scaled;
    logic [ADS_SAMPLE_W-1:0]   derived_current_ch2;
    logic [ADS_ANGLE_W-1:0]    sensor_angle;
    logic [ADS_ANGLE_W-1:0]    mechanical_angle;
    logic [ADS_ANGLE_W-1:0]    electrical_angle;
    logic [ADS_SAMPLE_W-1:0]   supply_voltage_ch;
    logic [ADS_SAMPLE_W-1:0]   analog_target;
    logic                      analog_target_valid;
  } ads_result_s;

endpackage

// [tb/adc_scaling_angle_engine_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_scaling_angle_engine_bench;
  import ads_pkg::*;
  localparam int PW = 12;
  localparam int GS = 8;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        out_ready = 1'b0;
  logic        in_valid, in_ready, out_valid, brake_out, exp_brake, hold, rnd;
  logic [4:0]  neg_input_gnd;
  ads_sample_s in_sample;
  ads_cfg_s    cfg;
  ads_result_s out_result;
  ads_result_s q[$];
  int          n_mismatch = 0;
  int          checks = 0;
  logic [15:0] vm[7] = '{16'h3FFF, 16'h8000, 16'hC000, 16'h8000, 16'h4000, 16'hFFFF, 16'h0000};

  always #5 sys_clk = ~sys_clk;

  ads_engine #(.POS_W(PW), .GAIN_SHIFT(GS)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_sample(in_sample), .cfg(cfg), .out_ready(out_ready), .in_ready(in_ready), .out_valid(out_valid),
    .out_result(out_result), .brake_out(brake_out), .neg_input_gnd(neg_input_gnd));

  ads_src_model src (.sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample));

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Clip to the symmetric range; the most negative code is never produced
  function automatic logic [15:0] sat(input logic signed [33:0] v);
    if (v > 32767) return 16'h7FFF;
    if (v < -32767) return 16'h8001;
    return v[15:0];
  endfunction

  // Offset subtracted as unsigned, gain signed, then shifted and clipped
  function automatic logic [15:0] sc(input logic [15:0] r, input logic [15:0] o, input logic [15:0] g);
    logic signed [33:0] p;
    p = ($signed({1'b0, r}) - $signed({1'b0, o})) * $signed(g);
    return sat(p >>> GS);
  endfunction

  function automatic ads_result_s model(input ads_sample_s s);
    ads_result_s        r;
    logic signed [33:0] t;
    logic [15:0]        a;
    r = '0;
    r.raw = s.raw;
    if (cfg.inject_sel) begin
      r.raw[0] = cfg.inject_ch0;
      r.raw[1] = cfg.inject_ch1;
    end
    for (int i = 0; i < 5; i++) r.scaled[i] = sc(r.raw[i], cfg.offset[i], cfg.gain[i]);
    t = $signed(r.scaled[0]);
    t = -(t + $signed(r.scaled[1]));
    r.derived_current_ch2 = sat(t);
    a = s.pos_reading << (16 - PW);
    r.sensor_angle = a;
    r.mechanical_angle = cfg.offset_sub ? a - cfg.angle_offset : a + cfg.angle_offset;
    r.electrical_angle = 16'(r.mechanical_angle * cfg.pole_pairs);
    r.supply_voltage_ch = r.raw[ADS_SUPPLY_VOLTAGE_CH];
    r.analog_target = cfg.target_from_gpa ? r.raw[ADS_GP_ANALOG_IN_A] : 16'h0000;
    r.analog_target_valid = cfg.target_from_gpa;
    return r;
  endfunction

  function automatic ads_sample_s rs();
    ads_sample_s s;
    for (int i = 0; i < 8; i++) s.raw[i] = 16'($urandom);
    s.pos_reading = 16'($urandom);
    return s;
  endfunction

  // Note the expectation, hand the set over, then check the brake hysteresis
  task automatic push(input ads_sample_s s, input int gap);
    q.push_back(model(s));
    src.send(s, gap);
    if (s.raw[ADS_SUPPLY_VOLTAGE_CH] >= cfg.brake_on_thr) exp_brake = 1'b1;
    else if (s.raw[ADS_SUPPLY_VOLTAGE_CH] <= cfg.brake_off_thr) exp_brake = 1'b0;
    #1 chk(brake_out === exp_brake, "brake output");
  endtask

  task automatic drain(input string name);
    src.idle();
    for (int i = 0; i < 300 && q.size() != 0; i++) @(posedge sys_clk);
    #1 chk(q.size() == 0, "results missing");
    $display("test %s done", name);
  endtask

  // Consumer readiness, optionally random, changed just after each edge
  always @(posedge sys_clk) begin
    #1;
    out_ready = !hold && (!rnd || $urandom_range(2) != 0);
  end

  // Result monitor: settled values at the falling edge decide the next handshake
  always @(negedge sys_clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      if (q.size() == 0) chk(1'b0, "unexpected result");
      else chk(out_result === q.pop_front(), "result mismatch");
    end
  end

  // Watchdog sized well above the expected run length
  initial begin
    #300000;
    chk(1'b0, "timeout");
    results();
  end

  initial begin
    cfg = '0;
    hold = 1'b0;
    rnd = 1'b0;
    exp_brake = 1'b0;
    void'($urandom(32'h643E));
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    cfg.single_ended = 5'h15;
    @(posedge sys_clk);
    #1 chk(neg_input_gnd === 5'h15, "negative leg grounding");
    $display("test single_ended done");
    for (int i = 0; i < 5; i++) begin
      cfg.offset[i] = 16'($urandom);
      cfg.gain[i] = 16'($urandom);
    end
    cfg.angle_offset = 16'($urandom);
    cfg.pole_pairs = 8'($urandom);
    cfg.brake_on_thr = 16'($urandom);
    cfg.brake_off_thr = 16'($urandom);
    rnd = 1'b1;
    repeat (40) push(rs(), $urandom_range(2));
    drain("random");
    // Saturation corners, exact most-negative result, injection and subtraction
    rnd = 1'b0;
    cfg.offset = {16'h1234, 16'h0000, 16'h8000, 16'hFFFF, 16'hFFFF};
    cfg.gain = {16'h8001, 16'hFF00, 16'h0100, 16'h7FFF, 16'h7FFF};
    cfg.inject_sel = 1'b1;
    cfg.inject_ch0 = 16'h0000;
    cfg.inject_ch1 = 16'h0000;
    cfg.offset_sub = 1'b1;
    cfg.target_from_gpa = 1'b1;
    push('0, 0);
    push('1, 0);
    repeat (10) push(rs(), 0);
    drain("corners");
    // Two results buffered under a stall, the third refused until space frees
    hold = 1'b1;
    push(rs(), 0);
    push(rs(), 0);
    @(posedge sys_clk);
    #1 chk(in_ready === 1'b0, "buffer should refuse");
    chk(out_valid === 1'b1, "buffered result hidden");
    #2 hold = 1'b0;
    push(rs(), 0);
    drain("buffer");
    cfg.brake_on_thr = 16'hC000;
    cfg.brake_off_thr = 16'h4000;
    foreach (vm[i]) begin
      ads_sample_s s;
      s = rs();
      s.raw[ADS_SUPPLY_VOLTAGE_CH] = vm[i];
      push(s, 1);
    end
    drain("brake");
    results();
  end
endmodule

`default_nettype wire

// [tb/ads_src_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Sample-set source standing in for the modulator front end
module ads_src_model
  import ads_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  in_ready,
  output logic       in_valid,
  output ads_sample_s in_sample
);
  initial begin
    in_valid  = 1'b0;
    in_sample = '0;
  end

  // Released lines show the inverse so stale data is never mistaken for fresh
  task automatic idle();
    if (in_valid) begin
      in_valid  = 1'b0;
      in_sample = ~in_sample;
    end
  endtask

  // All channels offered together as one set, held until taken
  task automatic send(input ads_sample_s s, input int gap);
    logic ok;
    if (gap > 0) begin
      idle();
      repeat (gap) begin
        @(posedge sys_clk);
        #1;
      end
    end
    in_valid  = 1'b1;
    in_sample = s;
    forever begin
      ok = in_ready;
      @(posedge sys_clk);
      if (ok) break;
      #1;
    end
  endtask
endmodule

`default_nettype wire
